//--- include/world_switch_pkg.sv
// Constants and types shared by the guest world-switch block.
package world_switch_pkg;
   // Feature vector bit positions.
   localparam int BIT_OBFUSCATE   = 14;
   localparam int BIT_SIBLING     = 15;
   localparam int BIT_SECURE_TS   = 9;
   localparam int BIT_BTB_ISOLATE = 7;
   localparam int BIT_SAMPLE_ENC  = 12;
   // Control-block sampling enable: bit 2 of the word at offset B8h.
   localparam logic [11:0] CB_SAMPLE_OFFSET = 12'h0B8;
   localparam int          BIT_SAMPLE_CB    = 2;
   // Register addresses.
   localparam logic [31:0] ADDR_TS_FREQ   = 32'hC0010134;
   localparam logic [31:0] ADDR_WAKE_CMD  = 32'hC0010137;
   localparam logic [31:0] ADDR_SPECULATION_CONTROL = 32'h00000048;
   localparam logic [31:0] ADDR_FETCH_PA  = 32'hC0011F00;
   localparam logic [31:0] ADDR_DATA_PA   = 32'hC0011F01;
   // Reset values.
   localparam logic [63:0] RST_WAKE_CMD  = 64'h0;
   localparam logic [63:0] RST_SPECULATION_CONTROL = 64'h0;
   localparam logic [63:0] RST_NONCE     = 64'h0;
   // Speculation control field holding the indirect-branch restriction.
   localparam int BIT_INDIRECT_BRANCH_RESTRICT = 0;
   // Exit code reported when the sibling thread is not idle (value arbitrary).
   localparam logic [7:0] SIBLING_NOT_IDLE_EXIT_CODE = 8'h5A;
   // Scale factor layout: 8 integer bits, 32 fraction bits.
   localparam int SCALE_INT_BITS  = 8;
   localparam int SCALE_FRAC_BITS = 32;
   localparam int SCALE_BITS      = SCALE_INT_BITS + SCALE_FRAC_BITS;
   // Nonce generator.
   localparam logic [63:0] LFSR_TAPS = 64'hD800000000000000;
   localparam logic [63:0] LFSR_SEED = 64'h0000000000000001;
   // Number of sampling registers swapped on world switch.
   localparam int SAMPLE_REGS = 10;
   typedef enum logic [1:0]
   {
      ST_HOST  = 2'b00,
      ST_CHECK = 2'b01,
      ST_GUEST = 2'b11
   } world_state_t;
endpackage

//--- hdl/nonce_lfsr.sv
// One step of the 64-bit Galois shift register that renews the nonce.
`timescale 1ns/100ps
`default_nettype none
module nonce_lfsr
   import world_switch_pkg::*;
(
   // State in and out.
   input  wire logic [63:0] cur,
   output logic      [63:0] nxt
);
   logic [63:0] seedOrCur;

   // An all-zero nonce would lock the register, so it restarts from a seed.
   assign seedOrCur = (cur == 64'h0) ? LFSR_SEED : cur;
   assign nxt = seedOrCur[0] ? ((seedOrCur >> 1) ^ LFSR_TAPS) : (seedOrCur >> 1);
endmodule
`default_nettype wire

//--- hdl/guest_isolation_world_switch.sv
// Guest world-switch extensions of the virtualization unit.
//
// Summary of operation
// [RQ1] With feature bit 14, obfuscate protected registers on exit, undo on entry.
// [RQ2] Obfuscation is XOR with the eight-byte nonce from the save area.
// [RQ3] Every automatic exit of a protected guest renews the nonce pseudo-randomly.
// [RQ4] Software should seed a new save area nonce with a random value.
// [RQ5] Feature bit 15 entry needs sibling idle in host mode, else idle-required exit.
// [RQ6] Hypervisor halts or idles the sibling before entering such a guest.
// [RQ7] Idle thread stays idle on wake while sibling runs a protected guest.
// [RQ8] Held wake writes the wakeup command once, only in extended controller mode.
// [RQ9] Software programs the wakeup command as an interrupt to the sibling.
// [RQ10] Feature bit 9: guest counter reads return counter times scale plus addend.
// [RQ11] Secure time ignores nominal frequency, host ratio and control-block addend.
// [RQ12] Scale is unsigned fixed point, eight integer and thirty-two fraction bits.
// [RQ13] Frequency register reads MHz; writes or non-secure reads fault with zero.
// [RQ14] A secure-time guest should not write the counter; later reads undefined.
// [RQ15] Host mode uses host speculation control only; writes update host copy.
// [RQ16] Entry loads guest copy; ordinary guests use host OR guest.
// [RQ17] Guest writes update guest copy; exit saves it and reverts to host.
// [RQ18] Isolated secure guests: host indirect-branch bit does not override guest.
// [RQ19] Sampling virtualization: control bit 2 at B8h, or feature bit 12 encrypted.
// [RQ20] Ten sampling registers have guest copies swapped on entry and exit.
// [RQ21] Virtualized: physical-address registers and valid bits read zero, writes dropped.
// [RQ22] Without virtual delivery a guest sampling interrupt goes nowhere.
// [RQ23] Scaled stamp is full product shifted right 32, plus addend, truncated.
// [RQ24] Nonce renewal uses a 64-bit shift register stepped once per exit of an obfuscating guest.
`timescale 1ns/100ps
`default_nettype none
module guest_isolation_world_switch
   import world_switch_pkg::*;
(
   // Clock and reset.
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   // World switch requests and per-guest configuration.
   input  wire logic                     entryReq,
   input  wire logic                     exitReq,
   input  wire logic                     secureGuest,
   input  wire logic                     encryptedGuest,
   input  wire logic [63:0]              guestFeatureVector,
   input  wire logic [63:0]              controlBlockSampleWord,
   input  wire logic                     siblingIdle,
   input  wire logic                     siblingHost,
   output logic                          entryDone,
   output logic                          entryFail,
   output logic      [7:0]               exitCode_q,
   output logic                          guestMode,
   // Save area fields loaded at entry.
   input  wire logic [63:0]              nonceIn,
   input  wire logic [SCALE_BITS-1:0]    guestTimestampMultiplier,
   input  wire logic [63:0]              guestTimestampAddend,
   input  wire logic [63:0]              guestSpecIn,
   input  wire logic [64*SAMPLE_REGS-1:0] sampleGuestIn,
   // Save area fields written at exit.
   output logic      [63:0]              nonceOut_q,
   output logic      [63:0]              guestSpecOut_q,
   output logic      [64*SAMPLE_REGS-1:0] sampleSaveOut_q,
   // Protected register stream.
   input  wire logic                     protValid,
   input  wire logic [63:0]              protData,
   output logic                          protOutValid_q,
   output logic      [63:0]              protOut_q,
   // Time stamp read.
   input  wire logic [63:0]              timestampCounter,
   input  wire logic [15:0]              nominalMhz,
   input  wire logic                     timestampRead,
   output logic                          timestampValid_q,
   output logic      [63:0]              timestampValue_q,
   // Register access.
   input  wire logic                     msrValid,
   input  wire logic                     msrWrite,
   input  wire logic [31:0]              msrAddr,
   input  wire logic [63:0]              msrWdata,
   output logic                          msrDone_q,
   output logic                          msrFault_q,
   output logic      [63:0]              msrRdata_q,
   // Effective speculation control and live sampling registers.
   output logic      [63:0]              effectiveSpec_q,
   output logic      [64*SAMPLE_REGS-1:0] sampleLive,
   // Sampling valid bits and interrupt.
   input  wire logic                     fetchValidRaw,
   input  wire logic                     dataValidRaw,
   output logic                          fetchPhysValid,
   output logic                          dataPhysValid,
   input  wire logic                     sampleIrq,
   input  wire logic                     virtualIcEnable,
   input  wire logic                     nmiVirtEnable,
   output logic                          sampleIrqGuest_q,
   output logic                          sampleIrqHost_q,
   // Idle wake hold.
   input  wire logic                     threadIdle,
   input  wire logic                     wakeEvent,
   input  wire logic                     siblingInProtectedGuest,
   input  wire logic                     extendedIcMode,
   output logic                          wakeHeld,
   output logic                          icrWrite_q,
   output logic      [63:0]              icrData_q
);
   world_state_t state_q;
   logic [63:0]  nonce_q;
   logic [63:0]  nonceNext;
   logic         obfuscate_q;
   logic         secureTs_q;
   logic         btbIsolate_q;
   logic         sampleVirt_q;
   logic [SCALE_BITS-1:0] scale_q;
   logic [63:0]  addend_q;
   logic [63:0]  hostSpec_q;
   logic [63:0]  guestSpec_q;
   logic [63:0]  wakeCmd_q;
   logic [63:0]  fetchPa_q;
   logic [63:0]  dataPa_q;
   logic [63:0]  sampleHost_q [SAMPLE_REGS];
   logic [63:0]  sampleCur_q [SAMPLE_REGS];
   logic         wakeSent_q;
   logic         siblingOk;
   logic         sampleVirtNow;
   logic         enterNow;
   logic         inGuest;
   logic [SCALE_BITS+63:0] product;
   logic [63:0]  freqMhz;
   logic [SCALE_BITS+15:0] freqProduct;
   logic [63:0]  branchMask;

   assign inGuest   = (state_q == ST_GUEST);
   assign guestMode = inGuest;
   assign siblingOk = siblingIdle && siblingHost;
   assign sampleVirtNow = encryptedGuest ? guestFeatureVector[BIT_SAMPLE_ENC]
                          : controlBlockSampleWord[BIT_SAMPLE_CB]; // see [RQ19]
   assign enterNow  = (state_q == ST_CHECK)
                      && (!guestFeatureVector[BIT_SIBLING] || !secureGuest || siblingOk);
   assign entryDone = enterNow;
   assign entryFail = (state_q == ST_CHECK) && !enterNow; // see [RQ5]

   nonce_lfsr u_nonce_lfsr
   (
      .cur (nonce_q),
      .nxt (nonceNext)
   );

   // World switch sequencing.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q <= ST_HOST;
      end
      else
      begin
         case (state_q)
            ST_HOST:  if (entryReq) state_q <= ST_CHECK;
            ST_CHECK: state_q <= enterNow ? ST_GUEST : ST_HOST;
            ST_GUEST: if (exitReq) state_q <= ST_HOST;
            default:  state_q <= ST_HOST;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         exitCode_q <= 8'h00;
      end
      else if (entryFail)
      begin
         exitCode_q <= SIBLING_NOT_IDLE_EXIT_CODE; // see [RQ5]
      end
   end

   // Per-guest modes latched on a successful entry.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         obfuscate_q  <= 1'b0;
         secureTs_q   <= 1'b0;
         btbIsolate_q <= 1'b0;
         sampleVirt_q <= 1'b0;
         scale_q      <= '0;
         addend_q     <= 64'h0;
      end
      else if (enterNow)
      begin
         obfuscate_q  <= secureGuest && guestFeatureVector[BIT_OBFUSCATE]; // see [RQ1]
         secureTs_q   <= secureGuest && guestFeatureVector[BIT_SECURE_TS]; // see [RQ10]
         btbIsolate_q <= secureGuest && guestFeatureVector[BIT_BTB_ISOLATE];
         sampleVirt_q <= sampleVirtNow; // see [RQ19]
         scale_q      <= guestTimestampMultiplier;
         addend_q     <= guestTimestampAddend;
      end
   end

   // Nonce: loaded from the save area on entry, renewed on each exit of an obfuscating guest.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         nonce_q    <= RST_NONCE;
         nonceOut_q <= RST_NONCE;
      end
      else if (enterNow)
      begin
         nonce_q <= nonceIn; // see [RQ2]
      end
      else if (inGuest && exitReq && obfuscate_q)
      begin
         nonce_q    <= nonceNext; // see [RQ3] see [RQ24]
         nonceOut_q <= nonceNext; // see [RQ3]
      end
   end

   // Register stream: XOR is its own inverse, so one path serves exit and entry.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         protOutValid_q <= 1'b0;
         protOut_q      <= 64'h0;
      end
      else
      begin
         protOutValid_q <= protValid;
         if (protValid)
         begin
            protOut_q <= obfuscate_q ? (protData ^ nonce_q) : protData; // see [RQ1] see [RQ2]
         end
      end
   end

   // Scaled time stamp; the host ratio and control-block addend never enter here.
   assign product = timestampCounter * scale_q; // see [RQ12]
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         timestampValid_q <= 1'b0;
         timestampValue_q <= 64'h0;
      end
      else
      begin
         timestampValid_q <= timestampRead;
         if (timestampRead)
         begin
            timestampValue_q <= (inGuest && secureTs_q)
                                ? (product[SCALE_FRAC_BITS+63:SCALE_FRAC_BITS] + addend_q)
                                : timestampCounter; // see [RQ10] see [RQ11] see [RQ23]
         end
      end
   end

   // Guest frequency in MHz.
   assign freqProduct = nominalMhz * scale_q;
   assign freqMhz     = 64'(freqProduct[SCALE_BITS+15:SCALE_FRAC_BITS]); // see [RQ13]

   // Register access; every access answers one cycle later.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         msrDone_q   <= 1'b0;
         msrFault_q  <= 1'b0;
         msrRdata_q  <= 64'h0;
         wakeCmd_q   <= RST_WAKE_CMD;
         fetchPa_q   <= 64'h0;
         dataPa_q    <= 64'h0;
      end
      else
      begin
         msrDone_q  <= msrValid;
         msrFault_q <= 1'b0;
         msrRdata_q <= 64'h0;
         if (msrValid)
         begin
            case (msrAddr)
               ADDR_TS_FREQ:
                  if (msrWrite || !(inGuest && secureTs_q))
                     msrFault_q <= 1'b1; // see [RQ13]
                  else
                     msrRdata_q <= freqMhz; // see [RQ13]
               ADDR_WAKE_CMD:
                  if (msrWrite)
                     wakeCmd_q <= msrWdata;
                  else
                     msrRdata_q <= wakeCmd_q;
               ADDR_SPECULATION_CONTROL:
                  if (!msrWrite)
                     msrRdata_q <= inGuest ? guestSpec_q : hostSpec_q;
               ADDR_FETCH_PA:
                  if (!(inGuest && sampleVirt_q))
                  begin
                     if (msrWrite)
                        fetchPa_q <= msrWdata;
                     else
                        msrRdata_q <= fetchPa_q;
                  end // see [RQ21]
               ADDR_DATA_PA:
                  if (!(inGuest && sampleVirt_q))
                  begin
                     if (msrWrite)
                        dataPa_q <= msrWdata;
                     else
                        msrRdata_q <= dataPa_q;
                  end // see [RQ21]
               default:
                  msrFault_q <= 1'b1;
            endcase
         end
      end
   end

   assign fetchPhysValid = fetchValidRaw && !(inGuest && sampleVirt_q); // see [RQ21]
   assign dataPhysValid  = dataValidRaw && !(inGuest && sampleVirt_q); // see [RQ21]

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         hostSpec_q     <= RST_SPECULATION_CONTROL;
         guestSpec_q    <= RST_SPECULATION_CONTROL;
         guestSpecOut_q <= RST_SPECULATION_CONTROL;
      end
      else
      begin
         if (enterNow)
            guestSpec_q <= guestSpecIn; // see [RQ16]
         else if (msrValid && msrWrite && msrAddr == ADDR_SPECULATION_CONTROL)
         begin
            if (inGuest)
               guestSpec_q <= msrWdata; // see [RQ17]
            else
               hostSpec_q <= msrWdata; // see [RQ15]
         end
         if (inGuest && exitReq)
            guestSpecOut_q <= guestSpec_q; // see [RQ17]
      end
   end

   // Isolated guests keep their own restriction bit regardless of the host.
   assign branchMask = ~(64'(btbIsolate_q) << BIT_INDIRECT_BRANCH_RESTRICT); // see [RQ18]

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         effectiveSpec_q <= RST_SPECULATION_CONTROL;
      else if (inGuest && !exitReq)
         effectiveSpec_q <= (hostSpec_q & branchMask) | guestSpec_q; // see [RQ16] see [RQ18]
      else
         effectiveSpec_q <= hostSpec_q; // see [RQ15] see [RQ17]
   end

   // Host sampling values parked while guest copies are live.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sampleSaveOut_q <= '0;
         for (int i = 0; i < SAMPLE_REGS; i++)
         begin
            sampleHost_q[i] <= 64'h0;
            sampleCur_q[i]  <= 64'h0;
         end
      end
      else if (enterNow && sampleVirtNow)
      begin
         for (int i = 0; i < SAMPLE_REGS; i++)
         begin
            sampleHost_q[i] <= sampleCur_q[i];
            sampleCur_q[i]  <= sampleGuestIn[64*i +: 64]; // see [RQ20]
         end
      end
      else if (inGuest && exitReq && sampleVirt_q)
      begin
         for (int i = 0; i < SAMPLE_REGS; i++)
         begin
            sampleSaveOut_q[64*i +: 64] <= sampleCur_q[i]; // see [RQ20]
            sampleCur_q[i]              <= sampleHost_q[i];
         end
      end
   end

   always_comb
   begin
      sampleLive = '0;
      for (int i = 0; i < SAMPLE_REGS; i++)
         sampleLive[64*i +: 64] = sampleCur_q[i];
   end

   // Sampling interrupt routing.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sampleIrqGuest_q <= 1'b0;
         sampleIrqHost_q  <= 1'b0;
      end
      else
      begin
         sampleIrqGuest_q <= sampleIrq && inGuest && sampleVirt_q
                             && (virtualIcEnable || nmiVirtEnable); // see [RQ22]
         sampleIrqHost_q  <= sampleIrq && !(inGuest && sampleVirt_q); // see [RQ22]
      end
   end

   // Wake hold: the idle thread waits for its sibling to leave the guest.
   assign wakeHeld = threadIdle && siblingInProtectedGuest; // see [RQ7]

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wakeSent_q <= 1'b0;
         icrWrite_q <= 1'b0;
         icrData_q  <= 64'h0;
      end
      else
      begin
         icrWrite_q <= 1'b0;
         if (!wakeHeld)
            wakeSent_q <= 1'b0;
         else if (wakeEvent && !wakeSent_q)
         begin
            wakeSent_q <= 1'b1; // see [RQ8]
            if (extendedIcMode)
            begin
               icrWrite_q <= 1'b1; // see [RQ8]
               icrData_q  <= wakeCmd_q;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/world_switch_checker_assertions.sv
// Concurrent checks on the ports of the guest world-switch block.
`timescale 1ns/100ps
`default_nettype none
module world_switch_checker
   import world_switch_pkg::*;
(
   // Observed ports.
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        entryReq,
   input wire logic        secureGuest,
   input wire logic [63:0] guestFeatureVector,
   input wire logic        siblingIdle,
   input wire logic        siblingHost,
   input wire logic        entryDone,
   input wire logic        entryFail,
   input wire logic [7:0]  exitCode_q,
   input wire logic        guestMode,
   input wire logic        protValid,
   input wire logic        protOutValid_q,
   input wire logic        timestampRead,
   input wire logic [63:0] timestampCounter,
   input wire logic        timestampValid_q,
   input wire logic [63:0] timestampValue_q,
   input wire logic        msrValid,
   input wire logic        msrWrite,
   input wire logic [31:0] msrAddr,
   input wire logic        msrDone_q,
   input wire logic        msrFault_q,
   input wire logic        icrWrite_q,
   input wire logic        extendedIcMode,
   input wire logic        wakeHeld,
   input wire logic        threadIdle,
   input wire logic        siblingInProtectedGuest,
   input wire logic        sampleIrqGuest_q,
   input wire logic        virtualIcEnable,
   input wire logic        nmiVirtEnable
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   a_sibling_busy_fail: assert property (entryReq && !guestMode && secureGuest
      && guestFeatureVector[BIT_SIBLING] && !(siblingIdle && siblingHost)
      |=> entryFail && !entryDone ##1 exitCode_q == SIBLING_NOT_IDLE_EXIT_CODE)
      else $error("busy sibling did not refuse entry");
   a_entry_done_mode: assert property (entryDone |=> guestMode)
      else $error("guest mode missing after entry");
   a_prot_answer: assert property (protValid |=> protOutValid_q)
      else $error("protected word not answered");
   a_host_ts_raw: assert property (timestampRead && !guestMode |=> timestampValid_q
      && timestampValue_q == $past(timestampCounter))
      else $error("host counter read altered");
   a_freq_write_fault: assert property (msrValid && msrWrite && msrAddr == ADDR_TS_FREQ
      |=> msrDone_q && msrFault_q)
      else $error("frequency write not faulted");
   a_freq_host_fault: assert property (msrValid && !msrWrite && msrAddr == ADDR_TS_FREQ
      && !guestMode |=> msrFault_q)
      else $error("frequency read outside guest not faulted");
   a_wake_cause: assert property (icrWrite_q |-> $past(extendedIcMode) && $past(wakeHeld))
      else $error("command write without cause");
   a_wake_single: assert property (icrWrite_q |=> !icrWrite_q)
      else $error("command written twice");
   a_held_cause: assert property (wakeHeld |-> threadIdle && siblingInProtectedGuest)
      else $error("wake held without protected sibling");
   a_irq_delivery: assert property (sampleIrqGuest_q
      |-> $past(virtualIcEnable) || $past(nmiVirtEnable))
      else $error("sampling interrupt reached guest without delivery");
   c_fail: cover property (entryFail);
   c_done: cover property (entryDone);
   c_icr: cover property (icrWrite_q);
endmodule
bind guest_isolation_world_switch world_switch_checker world_switch_checker_i (.*);
`default_nettype wire

//--- testbench/test_guest_isolation_world_switch.sv
// Self-checking bench for the guest world-switch block.
`timescale 1ns/100ps
`default_nettype none
module test_guest_isolation_world_switch;
   import world_switch_pkg::*;
   localparam logic [63:0] WAKE = 64'h0000_0002_0000_00F1;
   logic ref_clk, reset, entryReq, exitReq, secureGuest, encryptedGuest, siblingIdle, siblingHost, protValid;
   logic timestampRead, msrValid, msrWrite, fetchValidRaw, dataValidRaw, sampleIrq, virtualIcEnable, nmiVirtEnable;
   logic threadIdle, wakeEvent, siblingInProtectedGuest, extendedIcMode, entryDone, entryFail, guestMode;
   logic protOutValid_q, timestampValid_q, msrDone_q, msrFault_q, fetchPhysValid, dataPhysValid;
   logic sampleIrqGuest_q, sampleIrqHost_q, wakeHeld, icrWrite_q;
   logic [63:0] guestFeatureVector, controlBlockSampleWord, nonceIn, guestTimestampAddend, guestSpecIn, protData;
   logic [63:0] timestampCounter, msrWdata, nonceOut_q, guestSpecOut_q, protOut_q, timestampValue_q, msrRdata_q;
   logic [63:0] effectiveSpec_q, icrData_q, icrLast;
   logic [SCALE_BITS-1:0] guestTimestampMultiplier;
   logic [64*SAMPLE_REGS-1:0] sampleGuestIn, sampleSaveOut_q, sampleLive;
   logic [15:0] nominalMhz;
   logic [31:0] msrAddr;
   logic [7:0] exitCode_q;
   int errors = 0;
   int checks = 0;
   int icrCount = 0;
   guest_isolation_world_switch guest_isolation_world_switch_i (.*);
   task chk(input logic [639:0] seen, input logic [639:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task msr(input logic w, input logic [31:0] a, input logic [63:0] d, input logic [63:0] er, input logic ef);
      @(posedge ref_clk);
      {msrValid, msrWrite, msrAddr, msrWdata} <= {1'b1, w, a, d};
      @(posedge ref_clk);
      msrValid <= 1'b0;
      #1 chk({msrDone_q, msrFault_q, msrRdata_q}, {1'b1, ef, er});
   endtask
   task enter(input logic ok);
      @(posedge ref_clk);
      entryReq <= 1'b1;
      @(posedge ref_clk);
      entryReq <= 1'b0;
      #1 chk({entryDone, entryFail}, {ok, !ok});
      @(posedge ref_clk);
      #1 chk(guestMode, ok);
   endtask
   task leave();
      @(posedge ref_clk);
      exitReq <= 1'b1;
      @(posedge ref_clk);
      exitReq <= 1'b0;
      #1 chk(guestMode, 1'b0);
   endtask
   task ts(input logic [63:0] c, input logic [63:0] e);
      @(posedge ref_clk);
      {timestampRead, timestampCounter} <= {1'b1, c};
      @(posedge ref_clk);
      timestampRead <= 1'b0;
      #1 chk({timestampValid_q, timestampValue_q}, {1'b1, e});
   endtask
   function automatic logic [63:0] scaled(input logic [63:0] c);
      scaled = 64'((128'(c) * 128'(guestTimestampMultiplier)) >> 32) + guestTimestampAddend;
   endfunction
   always @(posedge ref_clk)
      #1 if (icrWrite_q === 1'b1)
      begin
         icrCount++;
         icrLast = icrData_q;
      end
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      errors++;
      print_verdict();
   end
   initial
   begin
      reset = 1'b1;
      {entryReq, exitReq, secureGuest, encryptedGuest, siblingIdle, siblingHost, protValid, timestampRead} = '0;
      {msrValid, msrWrite, fetchValidRaw, dataValidRaw, sampleIrq, virtualIcEnable, nmiVirtEnable} = '0;
      {threadIdle, wakeEvent, siblingInProtectedGuest, extendedIcMode, msrAddr, msrWdata, protData} = '0;
      {guestFeatureVector, controlBlockSampleWord, timestampCounter} = '0;
      nonceIn = 64'h0123_4567_89AB_CDEF;
      guestTimestampMultiplier = 40'h01_8000_0000;
      guestTimestampAddend = 64'h7;
      guestSpecIn = 64'h4;
      nominalMhz = 16'd2000;
      for (int i = 0; i < SAMPLE_REGS; i++)
         sampleGuestIn[64*i +: 64] = 64'hA5A5_0000_0000_0000 + 64'(i);
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      msr(1'b0, ADDR_WAKE_CMD, 64'h0, RST_WAKE_CMD, 1'b0);
      msr(1'b1, ADDR_WAKE_CMD, WAKE, 64'h0, 1'b0);
      msr(1'b0, ADDR_WAKE_CMD, 64'h0, WAKE, 1'b0);
      msr(1'b1, ADDR_TS_FREQ, 64'h5, 64'h0, 1'b1);
      msr(1'b0, ADDR_TS_FREQ, 64'h0, 64'h0, 1'b1);
      msr(1'b0, 32'h0000_1234, 64'h0, 64'h0, 1'b1);
      msr(1'b1, ADDR_SPECULATION_CONTROL, 64'h1, 64'h0, 1'b0);
      msr(1'b1, ADDR_FETCH_PA, 64'hBEEF, 64'h0, 1'b0);
      ts(64'd1000, 64'd1000);
      @(posedge ref_clk);
      {secureGuest, siblingIdle, siblingHost, guestFeatureVector} <= {3'b110, 64'h0000_C200};
      enter(1'b0);
      chk(exitCode_q, SIBLING_NOT_IDLE_EXIT_CODE);
      @(posedge ref_clk);
      siblingHost <= 1'b1;
      enter(1'b1);
      ts(64'd1000, scaled(64'd1000));
      ts(64'hFFFF_FFFF_FFFF_FFFF, scaled(64'hFFFF_FFFF_FFFF_FFFF));
      msr(1'b0, ADDR_TS_FREQ, 64'h0, 64'd3000, 1'b0);
      @(posedge ref_clk);
      {protValid, protData} <= {1'b1, 64'hFFFF_0000_1234_5678};
      @(posedge ref_clk);
      protValid <= 1'b0;
      #1 chk(protOut_q, 64'hFFFF_0000_1234_5678 ^ nonceIn);
      chk(effectiveSpec_q, 64'h5);
      msr(1'b1, ADDR_SPECULATION_CONTROL, 64'h2, 64'h0, 1'b0);
      msr(1'b0, ADDR_SPECULATION_CONTROL, 64'h0, 64'h2, 1'b0);
      chk(effectiveSpec_q, 64'h3);
      leave();
      chk(guestSpecOut_q, 64'h2);
      chk(nonceOut_q, (nonceIn >> 1) ^ LFSR_TAPS);
      @(posedge ref_clk);
      #1 chk(effectiveSpec_q, 64'h1);
      @(posedge ref_clk);
      {encryptedGuest, fetchValidRaw, dataValidRaw, guestFeatureVector} <= {3'b111, 64'h0000_1080};
      enter(1'b1);
      @(posedge ref_clk);
      #1 chk(effectiveSpec_q, 64'h4);
      chk(sampleLive, sampleGuestIn);
      chk({fetchPhysValid, dataPhysValid}, 2'b00);
      msr(1'b1, ADDR_DATA_PA, 64'hDEAD, 64'h0, 1'b0);
      msr(1'b0, ADDR_DATA_PA, 64'h0, 64'h0, 1'b0);
      msr(1'b0, ADDR_FETCH_PA, 64'h0, 64'h0, 1'b0);
      @(posedge ref_clk);
      sampleIrq <= 1'b1;
      @(posedge ref_clk);
      sampleIrq <= 1'b0;
      #1 chk({sampleIrqGuest_q, sampleIrqHost_q}, 2'b00);
      leave();
      chk(sampleSaveOut_q, sampleGuestIn);
      @(posedge ref_clk);
      {threadIdle, siblingInProtectedGuest, extendedIcMode} <= 3'b111;
      repeat (2)
      begin
         @(posedge ref_clk);
         wakeEvent <= 1'b1;
         @(posedge ref_clk);
         wakeEvent <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
      #1 chk({wakeHeld, icrLast}, {1'b1, WAKE});
      chk(icrCount, 1);
      @(posedge ref_clk);
      {siblingInProtectedGuest, extendedIcMode} <= 2'b00;
      @(posedge ref_clk);
      siblingInProtectedGuest <= 1'b1;
      @(posedge ref_clk);
      wakeEvent <= 1'b1;
      @(posedge ref_clk);
      wakeEvent <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk(icrCount, 1);
      @(posedge ref_clk);
      siblingInProtectedGuest <= 1'b0;
      @(posedge ref_clk);
      #1 chk(wakeHeld, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
